// ---- adcc_pkg.sv ----
/*
  constants, register map and carrier types for the converter control block.
  assumes a byte register port with one-cycle strobes and read data one cycle
  after the read strobe.
*/
// Operation
// RULE1: four analog channels give a 9-bit result read through two read-only bytes.
// RULE2: control bits 2..0 pick the channel to convert among the four; the code drives CHANNEL from bits 1..0 only and ignores bit 2.
// RULE3: control bits 5..3 set which port lines are analog and which digital.
// RULE4: an analog line loses digital function and pull-high, and powers the converter.
// RULE5: software starts a conversion by taking the start bit high then low.
// RULE6: the end-of-conversion flag at control bit 6 goes to one on a rising start bit.
// RULE7: at completion the flag clears and the interrupt request is raised if enabled.
// RULE8: software holds start low until the end-of-conversion flag reads zero.
// RULE9: software polls the flag or takes the interrupt, then reads both result bytes.
// RULE10: clock select bits 1..0 choose the conversion clock source.
// RULE11: software never uses clock select bit 7, which is for test only.
// RULE12: after a nonzero change of the analog field software pulses start within ten cycles.
// RULE13: clearing the analog field to zero needs no start pulse.
// RULE14: result bits are numbered 0 to 8 from least to most significant.
// RULE15: the high byte holds bits 8..1, the low byte bit 0 at its top, rest zero.
// RULE16: result bytes change only at completion, so reads during conversion show the last one.
package adcc_pkg;
  localparam logic [7:0] OFF_RESULT_LOW  = 8'h24;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h25;
  localparam logic [7:0] OFF_CONTROL     = 8'h26;
  localparam logic [7:0] OFF_CLOCK_SEL   = 8'h27;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h29;
  localparam logic [7:0] RST_CONTROL     = 8'h00;
  localparam logic [7:0] RST_CLOCK_SEL   = 8'h00;
  localparam logic [7:0] RST_MASK        = 8'h00;
  localparam int         BIT_START       = 7;
  localparam int         BIT_EOC         = 6;
  localparam int         RES_BITS        = 9;
  localparam int         CH_COUNT        = 4;
  localparam int         PORT_LINES      = 4;
  // terminal counts of the conversion clock divider per source code (divide by count plus one)
  localparam logic [3:0] DIV_SRC0        = 4'h1;
  localparam logic [3:0] DIV_SRC1        = 4'h3;
  localparam logic [3:0] DIV_SRC2        = 4'h7;
  localparam logic [3:0] DIV_SRC3        = 4'hF;
  localparam logic [3:0] CONV_STEPS      = 4'h9;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } adcc_bus_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_CONV  = 3'b100
  } adcc_state_t;
endpackage

// ---- adcc_top.sv ----
/*
  converter control: registers, start sequencing, successive approximation
  stepping, result capture, interrupt. the analog comparator lives outside and
  answers COMP_HIGH for the trial value on TRIAL, synchronous to REF_CLK.
*/
`timescale 1ns/100ps
module adcc_top
(
  input  wire logic       REF_CLK,
  input  wire logic       RESETN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       COMP_HIGH,
  output logic      [8:0] TRIAL,
  output logic      [1:0] CHANNEL,
  output logic      [3:0] ANALOG_EN,
  output logic      [3:0] PULLUP_OFF,
  output logic            CONV_POWER,
  output logic            IRQ
);
  adcc_pkg::adcc_bus_t   bus;
  adcc_pkg::adcc_state_t state;
  adcc_pkg::adcc_state_t next_state;
  logic [7:0] control;
  logic [7:0] clock_sel;
  logic [8:0] result;
  logic [8:0] sar;
  logic [3:0] step;
  logic [3:0] div_cnt;
  logic       irq_status;
  logic       irq_mask;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  wire wr_ctl   = bus.wr && bus.addr == adcc_pkg::OFF_CONTROL;
  wire wr_clk   = bus.wr && bus.addr == adcc_pkg::OFF_CLOCK_SEL;
  wire wr_stat  = bus.wr && bus.addr == adcc_pkg::OFF_IRQ_STATUS;
  wire wr_mask  = bus.wr && bus.addr == adcc_pkg::OFF_IRQ_MASK;
  wire start_q  = control[adcc_pkg::BIT_START];
  wire start_d  = bus.wdata[adcc_pkg::BIT_START];
  wire start_rise = wr_ctl && start_d && !start_q; // RULE6
  wire start_fall = wr_ctl && !start_d && start_q;
  // completion clears the flag even when a control write without a rising start lands with it
  wire next_eoc = start_rise || (control[adcc_pkg::BIT_EOC] && !done); // RULE7
  // field 5..3 gives number of analog lines counted from line 0, values 4 to 7 all giving four lines
  wire [2:0] pcfg = control[5:3]; // RULE3
  wire [3:0] div_sel = (clock_sel[1:0] == 2'd0) ? adcc_pkg::DIV_SRC0 :
                       (clock_sel[1:0] == 2'd1) ? adcc_pkg::DIV_SRC1 :
                       (clock_sel[1:0] == 2'd2) ? adcc_pkg::DIV_SRC2 :
                                                  adcc_pkg::DIV_SRC3; // RULE10
  wire tick = (div_cnt == div_sel);
  wire in_conv = (state == adcc_pkg::ST_CONV);
  wire done = in_conv && tick && step == adcc_pkg::CONV_STEPS - 4'h1;
  wire [8:0] bitmask = 9'h100 >> step;
  wire [8:0] trial = sar | bitmask;
  wire [8:0] sar_upd = COMP_HIGH ? sar : trial;
  wire [7:0] rd_mux =
    (bus.addr == adcc_pkg::OFF_RESULT_LOW)  ? {result[0], 7'h00} : // RULE15
    (bus.addr == adcc_pkg::OFF_RESULT_HIGH) ? result[8:1] : // RULE14
    (bus.addr == adcc_pkg::OFF_CONTROL)     ? control :
    (bus.addr == adcc_pkg::OFF_CLOCK_SEL)   ? clock_sel :
    (bus.addr == adcc_pkg::OFF_IRQ_STATUS)  ? {7'h00, irq_status} :
    (bus.addr == adcc_pkg::OFF_IRQ_MASK)    ? {7'h00, irq_mask} :
                                              8'h00;
  logic [3:0] next_analog;
  genvar g;
  generate
    for (g = 0; g < adcc_pkg::PORT_LINES; g++)
    begin : g_line
      assign next_analog[g] = (pcfg > 3'(g)); // RULE4
    end
  endgenerate

  always_comb
  begin
    next_state = state;
    unique case (state)
      adcc_pkg::ST_IDLE:
        if (start_rise)
          next_state = adcc_pkg::ST_ARMED;
      adcc_pkg::ST_ARMED:
        if (start_fall)
          next_state = adcc_pkg::ST_CONV; // RULE5
      adcc_pkg::ST_CONV:
        if (done)
          next_state = adcc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
    if (!RESETN)
      state <= adcc_pkg::ST_IDLE;
    else
      state <= next_state;

  // control: channel, port config, start written; eoc set/cleared by hardware
  always_ff @(posedge REF_CLK)
    if (!RESETN)
      control <= adcc_pkg::RST_CONTROL;
    else if (wr_ctl)
      control <= {start_d, next_eoc, bus.wdata[5:0]}; // RULE3
    else
      control[adcc_pkg::BIT_EOC] <= next_eoc; // RULE7

  always_ff @(posedge REF_CLK)
    if (!RESETN)
      clock_sel <= adcc_pkg::RST_CLOCK_SEL;
    else if (wr_clk)
      clock_sel <= bus.wdata;

  always_ff @(posedge REF_CLK)
    if (!RESETN || !in_conv || tick)
      div_cnt <= 4'h0;
    else
      div_cnt <= div_cnt + 4'h1;

  always_ff @(posedge REF_CLK)
    if (!RESETN || !in_conv)
    begin
      sar  <= 9'h000;
      step <= 4'h0;
    end
    else if (tick)
    begin
      sar  <= sar_upd;
      step <= step + 4'h1;
    end

  always_ff @(posedge REF_CLK)
    if (!RESETN)
      result <= 9'h000;
    else if (done)
      result <= sar_upd; // RULE16

  // set wins over write-one-to-clear
  always_ff @(posedge REF_CLK)
    if (!RESETN)
      irq_status <= 1'b0;
    else if (done)
      irq_status <= 1'b1; // RULE7
    else if (wr_stat && bus.wdata[0])
      irq_status <= 1'b0;

  always_ff @(posedge REF_CLK)
    if (!RESETN)
      irq_mask <= adcc_pkg::RST_MASK[0];
    else if (wr_mask)
      irq_mask <= bus.wdata[0];

  always_ff @(posedge REF_CLK)
    if (!RESETN)
    begin
      RDATA      <= 8'h00;
      TRIAL      <= 9'h000;
      CHANNEL    <= 2'b00;
      ANALOG_EN  <= 4'h0;
      PULLUP_OFF <= 4'h0;
      CONV_POWER <= 1'b0;
      IRQ        <= 1'b0;
    end
    else
    begin
      RDATA      <= bus.rd ? rd_mux : 8'h00; // RULE1
      TRIAL      <= in_conv ? trial : 9'h000;
      CHANNEL    <= control[1:0]; // RULE2
      ANALOG_EN  <= next_analog; // RULE4
      PULLUP_OFF <= next_analog;
      CONV_POWER <= |next_analog;
      IRQ        <= (irq_status || done) && irq_mask; // RULE7
    end

  a_eoc_on_start: assert property ( // RULE6
    @(posedge REF_CLK) disable iff (!RESETN)
    start_rise |=> control[adcc_pkg::BIT_EOC])
    else $error("eoc not set by start rise");
  a_eoc_clear_done: assert property ( // RULE7
    @(posedge REF_CLK) disable iff (!RESETN)
    done && !start_rise |=> !control[adcc_pkg::BIT_EOC] && irq_status)
    else $error("completion did not clear eoc or raise request");
  a_result_stable: assert property ( // RULE16
    @(posedge REF_CLK) disable iff (!RESETN)
    !done |=> $stable(result))
    else $error("result changed outside completion");
  a_irq_gated: assert property ( // RULE7
    @(posedge REF_CLK) disable iff (!RESETN)
    !irq_mask |=> !IRQ)
    else $error("interrupt while masked");
  a_low_byte_form: assert property ( // RULE15
    @(posedge REF_CLK) disable iff (!RESETN)
    bus.rd && bus.addr == adcc_pkg::OFF_RESULT_LOW |=> RDATA[6:0] == 7'h00)
    else $error("low byte spare bits not zero");
  a_high_byte_read: assert property ( // RULE14
    @(posedge REF_CLK) disable iff (!RESETN)
    bus.rd && bus.addr == adcc_pkg::OFF_RESULT_HIGH && !done
      |=> RDATA == result[8:1])
    else $error("high byte read wrong");
  a_channel_out: assert property ( // RULE2
    @(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl |=> ##1 CHANNEL == $past(bus.wdata[1:0], 2))
    else $error("channel output not following control");
  a_power_cfg: assert property ( // RULE4
    @(posedge REF_CLK) disable iff (!RESETN)
    pcfg == 3'd0 |=> !CONV_POWER && ANALOG_EN == 4'h0)
    else $error("converter powered with no analog line");
  a_conv_length: assert property ( // RULE10
    @(posedge REF_CLK) disable iff (!RESETN)
    in_conv && step == 4'h0 && div_cnt == 4'h0 && clock_sel[1:0] == 2'd0
      |-> ##[17:18] !in_conv)
    else $error("conversion length wrong");
  a_sel1_length: assert property ( // RULE10
    @(posedge REF_CLK) disable iff (!RESETN)
    in_conv && step == 4'h0 && div_cnt == 4'h0 && clock_sel[1:0] == 2'd1
      |-> ##[35:36] !in_conv)
    else $error("conversion length wrong for source 1");
  a_sel2_length: assert property ( // RULE10
    @(posedge REF_CLK) disable iff (!RESETN)
    in_conv && step == 4'h0 && div_cnt == 4'h0 && clock_sel[1:0] == 2'd2
      |-> ##[71:72] !in_conv)
    else $error("conversion length wrong for source 2");
  a_sel3_length: assert property ( // RULE10
    @(posedge REF_CLK) disable iff (!RESETN)
    in_conv && step == 4'h0 && div_cnt == 4'h0 && clock_sel[1:0] == 2'd3
      |-> ##[143:144] !in_conv)
    else $error("conversion length wrong for source 3");
  a_clock_keep: assert property ( // RULE10
    @(posedge REF_CLK) disable iff (!RESETN)
    !wr_clk |=> $stable(clock_sel))
    else $error("clock select changed without a write");
  a_trial_idle: assert property ( // RULE1
    @(posedge REF_CLK) disable iff (!RESETN)
    !in_conv |=> TRIAL == 9'h000)
    else $error("trial code outside conversion");
  a_trial_first: assert property ( // RULE14
    @(posedge REF_CLK) disable iff (!RESETN)
    in_conv && step == 4'h0 |-> trial[8])
    else $error("first trial is not the top bit");
  a_step_bound: assert property ( // RULE1
    @(posedge REF_CLK) disable iff (!RESETN)
    in_conv |-> step < adcc_pkg::CONV_STEPS)
    else $error("step count beyond result width");
  a_power_analog: assert property ( // RULE4
    @(posedge REF_CLK) disable iff (!RESETN)
    pcfg != 3'd0 |=> CONV_POWER && ANALOG_EN[0])
    else $error("analog line without converter power");
  a_pullup_cfg: assert property ( // RULE4
    @(posedge REF_CLK) disable iff (!RESETN)
    pcfg >= 3'd4 |=> PULLUP_OFF == 4'hF)
    else $error("pull-high left on an analog line");
  a_analog_shape: assert property ( // RULE3
    @(posedge REF_CLK) disable iff (!RESETN)
    ANALOG_EN inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("analog lines not counted from line 0");
  a_analog_count: assert property ( // RULE3
    @(posedge REF_CLK) disable iff (!RESETN)
    pcfg == 3'd2 |=> ANALOG_EN == 4'h3)
    else $error("two analog lines expected");
  a_cfg_store: assert property ( // RULE3
    @(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl |=> control[5:0] == $past(bus.wdata[5:0]))
    else $error("channel or port field not stored");
  a_control_keep: assert property ( // RULE2
    @(posedge REF_CLK) disable iff (!RESETN)
    !wr_ctl && !done |=> $stable(control))
    else $error("control changed without cause");
  a_control_read: assert property ( // RULE2
    @(posedge REF_CLK) disable iff (!RESETN)
    bus.rd && bus.addr == adcc_pkg::OFF_CONTROL |=> RDATA == $past(control))
    else $error("control read wrong");
  a_low_byte_bit: assert property ( // RULE15
    @(posedge REF_CLK) disable iff (!RESETN)
    bus.rd && bus.addr == adcc_pkg::OFF_RESULT_LOW
      |=> RDATA[7] == $past(result[0]))
    else $error("low byte top bit wrong");
  a_rdata_idle: assert property ( // RULE1
    @(posedge REF_CLK) disable iff (!RESETN)
    !bus.rd |=> RDATA == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property ( // RULE1
    @(posedge REF_CLK) disable iff (!RESETN)
    bus.rd && (bus.addr < adcc_pkg::OFF_RESULT_LOW ||
      bus.addr > adcc_pkg::OFF_IRQ_MASK) |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_start_store: assert property ( // RULE5
    @(posedge REF_CLK) disable iff (!RESETN)
    wr_ctl |=> control[adcc_pkg::BIT_START] == $past(start_d))
    else $error("start bit not stored");
  a_start_launch: assert property ( // RULE5
    @(posedge REF_CLK) disable iff (!RESETN)
    state == adcc_pkg::ST_ARMED && start_fall |=> in_conv)
    else $error("falling start did not launch conversion");
  a_armed_hold: assert property ( // RULE5
    @(posedge REF_CLK) disable iff (!RESETN)
    state == adcc_pkg::ST_ARMED && !start_fall
      |=> state == adcc_pkg::ST_ARMED)
    else $error("armed state left without falling start");
  a_eoc_armed: assert property ( // RULE6
    @(posedge REF_CLK) disable iff (!RESETN)
    state == adcc_pkg::ST_ARMED |-> control[adcc_pkg::BIT_EOC])
    else $error("eoc low while armed");
  a_eoc_in_conv: assert property ( // RULE6
    @(posedge REF_CLK) disable iff (!RESETN)
    in_conv |-> control[adcc_pkg::BIT_EOC])
    else $error("eoc low during conversion");
  a_done_leaves: assert property ( // RULE7
    @(posedge REF_CLK) disable iff (!RESETN)
    done |=> state == adcc_pkg::ST_IDLE)
    else $error("conversion did not end at completion");
  a_status_set: assert property ( // RULE7
    @(posedge REF_CLK) disable iff (!RESETN)
    done |=> irq_status)
    else $error("completion did not set request");
  a_irq_follow: assert property ( // RULE7
    @(posedge REF_CLK) disable iff (!RESETN)
    irq_status && irq_mask |=> IRQ)
    else $error("enabled request without interrupt");
  a_irq_no_cause: assert property ( // RULE7
    @(posedge REF_CLK) disable iff (!RESETN)
    !irq_status && !done |=> !IRQ)
    else $error("interrupt without request");
endmodule

// ---- adcc_tb.sv ----
/*
  self-checking bench for the converter control block.
  assumes adcc_top as declared; the comparator is modelled from TRIAL.
*/
`timescale 1ns/100ps
module testbench;
  logic        ref_clk;
  logic        resetn;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        comp_high;
  logic [8:0]  trial;
  logic [1:0]  channel;
  logic [3:0]  analog_en;
  logic [3:0]  pullup_off;
  logic        conv_power;
  logic        irq;
  logic [8:0]  level;
  logic [8:0]  prev;
  logic [7:0]  got;
  int          n_mismatch;
  int          checked;
  logic [7:0]  row_ctl [6] = '{8'h01, 8'h0A, 8'h13, 8'h1C, 8'h20, 8'h38};
  logic [3:0]  row_an  [6] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hF};
  logic [8:0]  vals    [4] = '{9'h15B, 9'h001, 9'h1FF, 9'h0A4};

  // comparator rejects a trial above the input level
  assign comp_high = (trial > level);

  adcc_top dut_u
  (
    .REF_CLK    (ref_clk),
    .RESETN     (resetn),
    .ADDR       (addr),
    .WDATA      (wdata),
    .WR         (wr),
    .RD         (rd),
    .RDATA      (rdata),
    .COMP_HIGH  (comp_high),
    .TRIAL      (trial),
    .CHANNEL    (channel),
    .ANALOG_EN  (analog_en),
    .PULLUP_OFF (pullup_off),
    .CONV_POWER (conv_power),
    .IRQ        (irq)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
      n_mismatch++;
    end
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic wait_eoc(input logic [7:0] c);
    int i;
    rd_reg(adcc_pkg::OFF_CONTROL);
    for (i = 0; i < 200 && got !== c; i++)
      rd_reg(adcc_pkg::OFF_CONTROL);
    if (i == 200)
    begin
      n_mismatch++;
      end_of_test();
    end
    chk(got, c);
  endtask

  task automatic convert(input logic [8:0] v);
    level <= v;
    wr_reg(adcc_pkg::OFF_CONTROL, 8'h88);
    rd_reg(adcc_pkg::OFF_CONTROL);
    chk(got, 8'hC8);
    wr_reg(adcc_pkg::OFF_CONTROL, 8'h08);
    rd_reg(adcc_pkg::OFF_RESULT_HIGH);
    chk(got, prev[8:1]);
    wait_eoc(8'h08);
    rd_reg(adcc_pkg::OFF_RESULT_HIGH);
    chk(got, v[8:1]);
    rd_reg(adcc_pkg::OFF_RESULT_LOW);
    chk(got, {v[0], 7'h00});
    chk(trial, 9'h000);
    prev = v;
  endtask

  initial
  begin
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    level = 9'h000;
    prev = 9'h000;
    n_mismatch = 0;
    checked = 0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    chk(trial, 9'h000);
    chk({channel, conv_power, irq, analog_en, pullup_off}, 12'h000);
    for (int a = 8'h24; a <= 8'h29; a++)
    begin
      rd_reg(a[7:0]);
      chk(got, 8'h00);
    end
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(adcc_pkg::OFF_CONTROL, row_ctl[i]);
      rd_reg(adcc_pkg::OFF_CONTROL);
      chk(got, row_ctl[i]);
      chk({conv_power, pullup_off, analog_en, channel},
          {|row_an[i], row_an[i], row_an[i], row_ctl[i][1:0]});
      if (row_an[i] != 4'h0)
      begin
        wr_reg(adcc_pkg::OFF_CONTROL, row_ctl[i] | 8'h80);
        wr_reg(adcc_pkg::OFF_CONTROL, row_ctl[i]);
        wait_eoc(row_ctl[i]);
      end
    end
    wr_reg(adcc_pkg::OFF_CLOCK_SEL, 8'h03);
    rd_reg(adcc_pkg::OFF_CLOCK_SEL);
    chk(got, 8'h03);
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(adcc_pkg::OFF_CLOCK_SEL, {6'h00, s[1:0]});
      wr_reg(adcc_pkg::OFF_IRQ_MASK, {7'h00, s == 0});
      convert(vals[s]);
      rd_reg(adcc_pkg::OFF_IRQ_STATUS);
      chk(got, 8'h01);
      chk(irq, s == 0);
      wr_reg(adcc_pkg::OFF_IRQ_STATUS, 8'h01);
      rd_reg(adcc_pkg::OFF_IRQ_STATUS);
      chk({got, irq}, 9'h000);
    end
    wr_reg(adcc_pkg::OFF_RESULT_HIGH, 8'hFF);
    rd_reg(adcc_pkg::OFF_RESULT_HIGH);
    chk(got, prev[8:1]);
    rd_reg(8'h30);
    chk(got, 8'h00);
    end_of_test();
  end
endmodule
